// ### logic/disk_ctrl_host_task_file.sv
// Task-file registers, drive decode and command sequencer of the controller
`timescale 1ns/1ns
`default_nettype none

module disk_ctrl_host_task_file
    import disk_ctrl_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    // Avalon-MM slave
    input  wire logic [5:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [3:0]  byteenable_in,
    input  wire logic [31:0] writedata_in,
    output logic [31:0]      readdata_out,
    output logic             waitrequest_out,
    // Drive lines
    input  wire logic        hd_ready_in,
    input  wire logic        hd_seek_complete_in,
    input  wire logic        hd_write_fault_in,
    input  wire logic        floppy_ready_in,
    input  wire logic        floppy_ready_jumper_in,
    input  wire logic        floppy_write_protect_in,
    // Disk engine
    input  wire logic        diag_start_in,
    input  wire logic [9:0]  target_cyl_in,
    input  wire logic        engine_done_in,
    input  wire logic [7:0]  engine_err_in,
    input  wire logic        engine_corrected_in,
    input  wire logic        engine_uncorr_in,
    input  wire logic        engine_mispos_in,
    input  wire logic        engine_buf_req_in,
    input  wire logic        engine_buf_done_in,
    output logic             op_start_out,
    output engine_op_t       op_code_out,
    output logic [7:0]       cmd_code_out,
    output logic [9:0]       seek_cyl_out,
    output logic             cmd_done_out,
    output logic             busy_out,
    output logic             drq_out,
    output logic [7:0]       complete_vector_out,
    output logic [7:0]       drq_vector_out,
    // Drive selection
    output logic [2:0]       hd_select_out,
    output logic [2:0]       head_out,
    output logic             floppy_unit_chosen_out,
    output logic [3:0]       floppy_unit_out,
    output logic             side_one_out,
    output logic             ecc_enable_out,
    output logic [10:0]      sector_bytes_out
);

    typedef struct packed {
        state_t                          st;
        logic                            ack;
        logic [7:0]                      rdata;
        logic [7:0]                      drive_head_select;
        logic [7:0]                      cmd;
        logic [7:0]                      err;
        logic [7:0]                      cvec;
        logic [7:0]                      dvec;
        logic                            diag;
        logic                            corr;
        logic                            drq;
        logic                            fd_wf;
        logic                            fd_sc;
        logic                            start;
        engine_op_t                      op;
        logic                            done;
        logic [3:0]                      retries;
        logic [NUM_DRIVES-1:0][9:0]      pos;
    } regs_t;

    regs_t       q;
    regs_t       d;
    logic        req;
    logic        wr_acc;
    logic [3:0]  idx;
    logic        floppy_sel;
    logic [2:0]  drv;
    logic        line_ready;
    logic        line_sc;
    logic        line_wf;
    logic        busy;
    logic        is_write_cmd;
    logic        cmd_acc;
    logic [7:0]  status;

    assign req    = read_in | write_in;
    assign idx    = address_in[5:2];
    // A write lands on the edge where waitrequest is seen low
    assign wr_acc = write_in & q.ack & byteenable_in[0];
    assign busy   = (q.st != S_IDLE);

    assign floppy_sel = q.drive_head_select[SDH_DRV_H] & q.drive_head_select[SDH_DRV_L];
    assign drv = floppy_sel ? FD_BASE + {1'b0, q.drive_head_select[2:1]}
                            : {1'b0, q.drive_head_select[SDH_DRV_H:SDH_DRV_L]};

    // Floppies lack seek-complete and write-fault, and ready unless jumpered, so they are synthesised
    assign line_ready = floppy_sel ? (floppy_ready_jumper_in ?
                        floppy_ready_in : 1'b1) : hd_ready_in;
    assign line_sc = floppy_sel ? q.fd_sc : hd_seek_complete_in;
    assign line_wf = floppy_sel ? q.fd_wf : hd_write_fault_in;

    // Diagnostic codes sit in the error register without the error bit
    assign status = {busy, line_ready, line_wf, line_sc, q.drq,
                     q.corr, 1'b0, (|q.err) & ~q.diag};

    assign is_write_cmd = (q.cmd[7:4] == CMD_WRITE_HI) |
                          (q.cmd[7:4] == CMD_FORMAT_HI);
    // Writes to the status address are commands; ignored while busy
    assign cmd_acc = wr_acc & (idx == IDX_STAT) & ~busy;

    always_comb begin
        d       = q;
        d.start = 1'b0;
        d.done  = 1'b0;
        d.ack   = req & ~q.ack;
        if (req & ~q.ack) begin
            unique case (idx)
                IDX_ERR:  d.rdata = q.err;
                IDX_SDH:  d.rdata = q.drive_head_select;
                IDX_STAT: d.rdata = status;
                default:  d.rdata = 8'h00;
            endcase
        end
        if (wr_acc) begin
            unique case (idx)
                IDX_CVEC: d.cvec = writedata_in[7:0];
                IDX_ERR:  d.dvec = writedata_in[7:0];
                IDX_SDH: begin
                    d.drive_head_select = writedata_in[7:0];
                    if (writedata_in[SDH_DRV_H] & writedata_in[SDH_DRV_L]) begin
                        d.fd_sc = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Buffer request beats a same-cycle buffer-done
        if (engine_buf_done_in) begin
            d.drq = 1'b0;
        end
        if (engine_buf_req_in) begin
            d.drq = 1'b1;
        end
        if (engine_corrected_in & busy) begin
            d.corr = 1'b1;
        end
        unique case (q.st)
            S_IDLE: begin
                if (cmd_acc | diag_start_in) begin
                    d.cmd     = cmd_acc ? writedata_in[7:0] : CMD_TEST;
                    d.err     = 8'h00;
                    d.corr    = 1'b0;
                    d.fd_wf   = 1'b0;
                    d.retries = 4'h0;
                    d.diag    = 1'b0;
                    // Undefined codes are passed on unchecked
                    if (!cmd_acc || writedata_in[7:0] == CMD_TEST) begin
                        d.diag  = 1'b1;
                        d.op    = OP_DIAG;
                        d.start = 1'b1;
                        d.st    = S_RUN;
                    end else begin
                        d.st = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                if (!line_ready || !line_sc || line_wf) begin
                    d.err[ERR_ABORT] = 1'b1;
                    d.st = S_FINISH;
                end else if (floppy_sel && is_write_cmd &&
                             floppy_write_protect_in) begin
                    d.fd_wf = 1'b1;
                    d.err[ERR_ABORT] = 1'b1;
                    d.st = S_FINISH;
                end else if (target_cyl_in != q.pos[drv]) begin
                    d.op    = OP_SEEK;
                    d.start = 1'b1;
                    d.st    = S_SEEK;
                end else begin
                    d.op    = OP_CMD;
                    d.start = 1'b1;
                    d.st    = S_RUN;
                end
            end
            S_SEEK: begin
                if (engine_done_in) begin
                    d.pos[drv] = target_cyl_in;
                    d.op       = OP_CMD;
                    d.start    = 1'b1;
                    d.st       = S_RUN;
                end
            end
            S_RUN: begin
                if (engine_uncorr_in) begin
                    d.err[ERR_UNC] = 1'b1;
                    d.st = S_FINISH;
                end else if (engine_mispos_in && !q.diag) begin
                    if (q.retries == RETRY_MAX) begin
                        d.err[ERR_IDNF] = 1'b1;
                        d.st = S_FINISH;
                    end else begin
                        d.retries = q.retries + 4'h1;
                        d.op      = OP_RECAL;
                        d.start   = 1'b1;
                        d.st      = S_RECAL;
                    end
                end else if (engine_done_in) begin
                    d.err = q.err | engine_err_in;
                    d.st  = S_FINISH;
                end
            end
            S_RECAL: begin
                if (engine_done_in) begin
                    d.pos[drv] = POS_RESET;
                    d.op       = OP_SEEK;
                    d.start    = 1'b1;
                    d.st       = S_RESEEK;
                end
            end
            S_RESEEK: begin
                if (engine_done_in) begin
                    d.pos[drv] = target_cyl_in;
                    d.op       = OP_CMD;
                    d.start    = 1'b1;
                    d.st       = S_RUN;
                end
            end
            S_FINISH: begin
                // Every ending, failed or not, takes this same path
                d.done = 1'b1;
                d.st   = S_IDLE;
            end
            default: d.st = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q      <= '0;
            q.st   <= S_IDLE;
            q.drive_head_select  <= SDH_RESET;
            q.cvec <= VEC_RESET;
            q.dvec <= VEC_RESET;
        end else begin
            q <= d;
        end
    end

    assign readdata_out        = {24'h000000, q.rdata};
    assign waitrequest_out     = req & ~q.ack;
    assign op_start_out        = q.start;
    assign op_code_out         = q.op;
    assign cmd_code_out        = q.cmd;
    assign seek_cyl_out        = target_cyl_in;
    assign cmd_done_out        = q.done;
    assign busy_out            = busy;
    assign drq_out             = q.drq;
    assign complete_vector_out = q.cvec;
    assign drq_vector_out      = q.dvec;

    always_comb begin
        hd_select_out = 3'h0;
        if (!floppy_sel) begin
            hd_select_out[q.drive_head_select[SDH_DRV_H:SDH_DRV_L]] = 1'b1;
        end
        floppy_unit_out = 4'h0;
        if (floppy_sel) begin
            floppy_unit_out[q.drive_head_select[2:1]] = 1'b1;
        end
        unique case (q.drive_head_select[SDH_SIZE_H:SDH_SIZE_L])
            2'b00: sector_bytes_out = SIZE_256;
            2'b01: sector_bytes_out = SIZE_512;
            2'b10: sector_bytes_out = SIZE_1024;
            2'b11: sector_bytes_out = SIZE_128;
        endcase
    end

    assign head_out               = floppy_sel ? 3'h0 : q.drive_head_select[2:0];
    assign floppy_unit_chosen_out = floppy_sel;
    assign side_one_out           = floppy_sel & q.drive_head_select[0];
    assign ecc_enable_out         = ~floppy_sel & q.drive_head_select[SDH_ECC];

    a_busy_on_cmd: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in) cmd_acc |=> $rose(busy_out) ##1 busy_out)
        else $error("busy not raised after command");

    a_cmd_ignored: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (wr_acc && idx == IDX_STAT && busy) |=> $stable(q.cmd))
        else $error("command written while busy");

    a_refuse_cmd: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (q.st == S_CHECK && (!line_ready || !line_sc || line_wf))
        |=> q.err[ERR_ABORT] && !op_start_out ##1 cmd_done_out)
        else $error("command ran with drive not usable");

    a_error_clear: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in) cmd_acc |=> q.err == 8'h00)
        else $error("error not cleared by new command");

    a_size_decode: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (wr_acc && idx == IDX_SDH && writedata_in[6:5] == 2'b11)
        |=> sector_bytes_out == SIZE_128)
        else $error("sector size decode wrong");

    a_drive_latch: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (wr_acc && idx == IDX_SDH && writedata_in[4:3] == 2'b10)
        |=> hd_select_out == 3'b100 && head_out == $past(writedata_in[2:0]))
        else $error("hard drive select not latched");

    a_floppy_side: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (wr_acc && idx == IDX_SDH && writedata_in[4:3] == 2'b11)
        |=> floppy_unit_out[$past(writedata_in[2:1])] &&
            side_one_out == $past(writedata_in[0]) && line_sc)
        else $error("floppy selection wrong");

    a_corr_sticky: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in) (q.corr && busy && !cmd_acc) |=> q.corr)
        else $error("corrected flag lost during command");

    a_uncorr_end: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in) (q.st == S_RUN && engine_uncorr_in)
        |=> q.err[ERR_UNC] ##1 cmd_done_out ##1 !busy_out)
        else $error("uncorrectable error not terminated");

    a_drq_clear: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (engine_buf_done_in && !engine_buf_req_in) |=> !drq_out)
        else $error("data request stuck after buffer done");

    a_recal_retry: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (q.st == S_RUN && engine_mispos_in && !engine_uncorr_in &&
         !q.diag && q.retries < RETRY_MAX)
        |=> op_start_out && op_code_out == OP_RECAL)
        else $error("no recalibrate on mis-position");

    a_implied_seek: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        (q.st == S_SEEK && engine_done_in)
        |=> op_start_out && op_code_out == OP_CMD &&
            q.pos[drv] == $past(target_cyl_in))
        else $error("implied seek did not update position");

endmodule

`default_nettype wire

// ### logic/disk_ctrl_pkg.sv
// Constants and types shared by the disk controller task-file block
package disk_ctrl_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [3:0] IDX_CVEC = 4'h0;  // write: completion vector
    localparam logic [3:0] IDX_ERR  = 4'h3;  // read: error, write: drq vector
    localparam logic [3:0] IDX_SDH  = 4'hD;  // drive_head_select
    localparam logic [3:0] IDX_STAT = 4'hF;  // read: status, write: command

    // drive_head_select fields
    localparam int SDH_ECC    = 7;
    localparam int SDH_SIZE_H = 6;
    localparam int SDH_SIZE_L = 5;
    localparam int SDH_DRV_H  = 4;
    localparam int SDH_DRV_L  = 3;

    // controller_status bit positions
    localparam int ST_BUSY  = 7;
    localparam int ST_READY = 6;
    localparam int ST_WF    = 5;
    localparam int ST_SC    = 4;
    localparam int ST_DRQ   = 3;
    localparam int ST_CORR  = 2;
    localparam int ST_ERR   = 0;

    // Error register bit positions
    localparam int ERR_UNC   = 6;
    localparam int ERR_IDNF  = 4;
    localparam int ERR_ABORT = 2;

    // Sector sizes in bytes
    localparam logic [10:0] SIZE_256  = 11'h100;
    localparam logic [10:0] SIZE_512  = 11'h200;
    localparam logic [10:0] SIZE_1024 = 11'h400;
    localparam logic [10:0] SIZE_128  = 11'h080;

    // Command codes the block itself interprets
    localparam logic [7:0] CMD_TEST     = 8'h90;
    localparam logic [3:0] CMD_WRITE_HI = 4'h3;
    localparam logic [3:0] CMD_FORMAT_HI = 4'h5;

    localparam logic [3:0] RETRY_MAX  = 4'h8;
    localparam int         NUM_DRIVES = 7;
    localparam logic [2:0] FD_BASE    = 3'h3;

    // Reset values
    localparam logic [7:0] SDH_RESET  = 8'h00;
    localparam logic [7:0] VEC_RESET  = 8'h0F;
    localparam logic [9:0] POS_RESET  = 10'h000;

    typedef enum logic [1:0] {
        OP_CMD   = 2'h0,
        OP_SEEK  = 2'h1,
        OP_RECAL = 2'h2,
        OP_DIAG  = 2'h3
    } engine_op_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_CHECK  = 3'b001,
        S_SEEK   = 3'b011,
        S_RUN    = 3'b010,
        S_FINISH = 3'b110,
        S_RECAL  = 3'b111,
        S_RESEEK = 3'b101
    } state_t;

endpackage

// ### verif/disk_engine_model.sv
// Behavioural disk engine answering the sequencer's operation starts
`timescale 1ns/1ns
`default_nettype none
module disk_engine_model
    import disk_ctrl_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       op_start_in,
    input  wire engine_op_t op_code_in,
    input  wire logic [3:0] delay_in,
    input  wire logic [1:0] fault_in,
    output logic            done_out,
    output logic            corrected_out,
    output logic            uncorr_out,
    output logic            mispos_out,
    output logic            buf_req_out,
    output logic            buf_done_out
);
    logic [3:0] cnt_q;
    logic       act_q;
    logic       mis_q;
    logic       cmd;
    engine_op_t op_q;

    assign cmd = act_q && op_q == OP_CMD;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {cnt_q, act_q, mis_q, done_out, corrected_out} <= '0;
            {uncorr_out, mispos_out, buf_req_out, buf_done_out} <= '0;
            op_q <= OP_CMD;
        end else begin
            {done_out, corrected_out, uncorr_out, mispos_out} <= '0;
            {buf_req_out, buf_done_out} <= '0;
            // One mis-position until fault_in leaves 3, so the retry can succeed
            if (fault_in != 2'h3) mis_q <= 1'b0;
            if (op_start_in) begin
                act_q <= 1'b1;
                op_q <= op_code_in;
                cnt_q <= delay_in;
                buf_req_out <= op_code_in == OP_CMD;
            end else if (act_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
                corrected_out <= cmd && fault_in == 2'h1;
            end else if (act_q) begin
                act_q <= 1'b0;
                buf_done_out <= cmd;
                if (cmd && fault_in == 2'h2) uncorr_out <= 1'b1;
                else if (cmd && fault_in == 2'h3 && !mis_q) begin
                    mispos_out <= 1'b1;
                    mis_q <= 1'b1;
                end else done_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/disk_ctrl_host_task_file_tb.sv
// Self-checking bench for the disk controller task-file block
`timescale 1ns/1ns
`default_nettype none
module disk_ctrl_host_task_file_tb;
    import disk_ctrl_pkg::*;
    logic        clk, nrst, rd, wr, hrdy, hsc, hwf, frdy, fjmp, fwp, diag;
    logic        wreq, wreq_n, op_st, done, busy, drq, fsel, side, ecc;
    logic        e_done, e_corr, e_unc, e_mis, e_req, e_bdone, drq_seen;
    logic        fsc_m, fwf_m, corr_m, erb_m;
    logic [5:0]  addr;
    logic [31:0] wdat, rdat, rdat_n;
    logic [9:0]  cyl, scyl;
    logic [3:0]  dly, funit;
    logic [1:0]  fault;
    logic [7:0]  ccode, cvec, dvec, sdh_m, eerr;
    logic [2:0]  hsel, head;
    logic [10:0] sbytes;
    engine_op_t  opc;
    logic [1:0]  ops_q[$];
    int          err_count, n_compared, cyc, ndone;

    disk_ctrl_host_task_file DUT (
        .core_clk_in(clk), .nrst_in(nrst), .address_in(addr), .read_in(rd),
        .write_in(wr), .byteenable_in(4'hF), .writedata_in(wdat),
        .readdata_out(rdat), .waitrequest_out(wreq), .hd_ready_in(hrdy),
        .hd_seek_complete_in(hsc), .hd_write_fault_in(hwf),
        .floppy_ready_in(frdy), .floppy_ready_jumper_in(fjmp),
        .floppy_write_protect_in(fwp), .diag_start_in(diag),
        .target_cyl_in(cyl), .engine_done_in(e_done), .engine_err_in(eerr),
        .engine_corrected_in(e_corr), .engine_uncorr_in(e_unc),
        .engine_mispos_in(e_mis), .engine_buf_req_in(e_req),
        .engine_buf_done_in(e_bdone), .op_start_out(op_st),
        .op_code_out(opc), .cmd_code_out(ccode), .seek_cyl_out(scyl),
        .cmd_done_out(done), .busy_out(busy), .drq_out(drq),
        .complete_vector_out(cvec), .drq_vector_out(dvec),
        .hd_select_out(hsel), .head_out(head), .floppy_unit_chosen_out(fsel),
        .floppy_unit_out(funit), .side_one_out(side), .ecc_enable_out(ecc),
        .sector_bytes_out(sbytes));

    disk_engine_model engine (
        .clk_in(clk), .nrst_in(nrst), .op_start_in(op_st), .op_code_in(opc),
        .delay_in(dly), .fault_in(fault), .done_out(e_done),
        .corrected_out(e_corr), .uncorr_out(e_unc), .mispos_out(e_mis),
        .buf_req_out(e_req), .buf_done_out(e_bdone));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Sampled mid-cycle so that edge-time updates never race the bench
    always @(negedge clk) begin
        wreq_n = wreq;
        rdat_n = rdat;
        if (op_st === 1'b1) ops_q.push_back(opc);
        if (done === 1'b1) ndone++;
        if (drq === 1'b1) drq_seen = 1'b1;
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        addr <= {idx, 2'b00};
        wr <= w;
        rd <= ~w;
        wdat <= {24'h0, d};
        do @(posedge clk); while (wreq_n !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        check(rdat_n, {24'h0, e});
    endtask

    function automatic logic [7:0] exp_stat();
        logic fl;
        fl = &sdh_m[4:3];
        return {1'b0, fl ? (fjmp ? frdy : 1'b1) : hrdy, fl ? fwf_m : hwf,
                fl ? fsc_m : hsc, 1'b0, corr_m, 1'b0, erb_m};
    endfunction

    task automatic chk_sdh(input logic [7:0] v);
        logic fl;
        fl = &v[4:3];
        bus(1'b1, IDX_SDH, v);
        sdh_m = v;
        fsc_m = fsc_m | fl;
        @(negedge clk);
        check(sbytes, v[6] ? (v[5] ? 128 : 1024) : (v[5] ? 512 : 256));
        check(fsel, fl);
        check(hsel, fl ? 3'h0 : 3'h1 << v[4:3]);
        check(head, fl ? 3'h0 : v[2:0]);
        check({funit, side}, fl ? {4'h1 << v[2:1], v[0]} : 5'h00);
        check(ecc, v[7] & ~fl);
        rd_chk(IDX_SDH, v);
    endtask

    task automatic run(input logic [7:0] c, input logic [7:0] ops,
                       input int n, input logic [7:0] erx, input logic cr);
        int         d0;
        logic [7:0] p;
        logic       fl;
        d0 = ndone;
        ops_q.delete();
        drq_seen = 1'b0;
        fl = &sdh_m[4:3];
        if (c === CMD_TEST) begin
            @(posedge clk);
            diag <= 1'b1;
            @(posedge clk);
            diag <= 1'b0;
        end else bus(1'b1, IDX_STAT, c);
        repeat (2) @(negedge clk);
        check(busy, 1'b1);
        while (busy !== 1'b0) @(negedge clk);
        // One more cycle so the done pulse is surely counted
        @(negedge clk);
        check(scyl, cyl);
        p = 8'h00;
        foreach (ops_q[i]) p = {p[5:0], ops_q[i]};
        check({8'(ops_q.size()), p}, {8'(n), ops});
        check(ndone, d0 + 1);
        check(drq_seen, n > 0 && ops[1:0] == OP_CMD);
        fwf_m = fl & fwp & (c[7:4] == CMD_WRITE_HI || c[7:4] == CMD_FORMAT_HI);
        erb_m = erx != 8'h00 && c != CMD_TEST;
        corr_m = cr;
        rd_chk(IDX_STAT, exp_stat());
        rd_chk(IDX_ERR, erx);
    endtask

    initial begin
        {nrst, rd, wr, hrdy, hsc, hwf, frdy, fjmp, fwp, diag} = '0;
        {fsc_m, fwf_m, corr_m, erb_m, drq_seen} = '0;
        {addr, wdat, cyl, fault, eerr} = '0;
        dly = 4'h2;
        sdh_m = SDH_RESET;
        {err_count, n_compared, cyc, ndone} = '0;
        void'($urandom(74));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        check({cvec, dvec}, {VEC_RESET, VEC_RESET});
        rd_chk(IDX_STAT, exp_stat());
        for (int i = 0; i < 128; i++) chk_sdh({1'($urandom), i[6:0]});
        p_vec: begin
            logic [15:0] v;
            v = 16'($urandom);
            bus(1'b1, IDX_CVEC, v[15:8]);
            bus(1'b1, IDX_ERR, v[7:0]);
            @(negedge clk);
            check({cvec, dvec}, v);
            rd_chk(IDX_CVEC, 8'h00);
        end
        hrdy <= 1'b1;
        hsc <= 1'b1;
        chk_sdh(8'h00);
        run(8'h20, 8'h00, 1, 8'h00, 1'b0);
        cyl <= 10'h015;
        run(8'h20, 8'h04, 2, 8'h00, 1'b0);
        run(8'h24, 8'h00, 1, 8'h00, 1'b0);
        fault <= 2'h1;
        run(8'h24, 8'h00, 1, 8'h00, 1'b1);
        fault <= 2'h2;
        run(8'h20, 8'h00, 1, 8'h40, 1'b0);
        fault <= 2'h3;
        run(8'h30, 8'h24, 4, 8'h00, 1'b0);
        fault <= 2'h0;
        for (int k = 0; k < 3; k++) begin
            hrdy <= k != 0;
            hsc <= k != 1;
            hwf <= k == 2;
            run(8'h20, 8'h00, 0, 8'h04, 1'b0);
        end
        {hrdy, hsc, hwf} <= 3'b110;
        dly <= 4'hF;
        bus(1'b1, IDX_STAT, 8'h20);
        bus(1'b1, IDX_STAT, 8'h70);
        bus(1'b0, IDX_STAT, 8'h00);
        check(rdat_n[7], 1'b1);
        check(ccode, 8'h20);
        while (busy !== 1'b0) @(negedge clk);
        @(posedge clk);
        erb_m = 1'b0;
        dly <= 4'h2;
        cyl <= 10'h000;
        hrdy <= 1'b0;
        hsc <= 1'b0;
        chk_sdh(8'h1C);
        rd_chk(IDX_STAT, exp_stat());
        run(8'h20, 8'h00, 1, 8'h00, 1'b0);
        fwp <= 1'b1;
        run(8'h30, 8'h00, 0, 8'h04, 1'b0);
        fwp <= 1'b0;
        fjmp <= 1'b1;
        run(8'h20, 8'h00, 0, 8'h04, 1'b0);
        frdy <= 1'b1;
        // Diagnostic code lands in the error register, status bit stays low
        eerr <= 8'h05;
        run(CMD_TEST, 8'h03, 1, 8'h05, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
